// *** shared/fbp_pkg.sv ***
// constants, types and carriers for the burst pacing and handshake block
// Summary of operation
// - Each granted service-request poll moves one burst as long as possible, from one to thirty-two words.
// - A burst is limited by the words held in the FIFO (input) or the free spaces in it (output).
// - During output, once the FIFO holds more than fifty-five words the burst ends by releasing burst_request_n.
// - During input, no burst is taken while fewer than eight words wait in the FIFO.
// - In FIFO handshake mode every low pulse of the control strobe lasts at least one hundred nanoseconds.
// - Output data stands on the data lines for one hundred nanoseconds before the control strobe rises.
// - Received data is taken only after a one hundred nanosecond deskew wait.
// - After the peripheral flag during output, the next word is placed and the strobe cycles low then high, with setup done first.
// - This block waits in standby and checks that the other party is powered before connecting; the peripheral model does no such check.
// - The two parties never both talk or both listen at the same time.
// - The peripheral end input and host end output may end a transfer cleanly when word counts differ.
// - In FIFO-mode output the strobe rises at least two clocks after data is ready and drops one clock after the flag.
// - In FIFO-mode output a falling edge on the peripheral end input before the next strobe aborts the pending word.
// - The peripheral flag is combined with the polarity select through an exclusive-NOR before the state machine.
package fbp_pkg;

  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned STROBE_LOW_NS = 100;
  localparam int unsigned DATA_SETUP_NS = 100;
  localparam int unsigned DESKEW_NS = 100;
  localparam int unsigned STROBE_DELAY_CLK = 2;
  // least times round up to whole cycles
  localparam int unsigned SETUP_RAW = (DATA_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_EFF = (SETUP_RAW > STROBE_DELAY_CLK) ? SETUP_RAW : STROBE_DELAY_CLK;
  localparam logic [2:0] SETUP_CYC = 3'(SETUP_EFF);
  localparam logic [2:0] DESKEW_CYC = 3'((DESKEW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [2:0] STROBE_LOW_CYC = 3'((STROBE_LOW_NS * CLK_MHZ + 999) / 1000);

  localparam logic [5:0] BURST_MAX = 6'h20;
  localparam logic [6:0] FIFO_DEPTH = 7'h40;
  localparam logic [6:0] OUT_HIGH_MARK = 7'h37;
  localparam logic [6:0] IN_MIN_WORDS = 7'h08;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_LOAD = 4'h1,
    S_SETUP = 4'h2,
    S_STROBE = 4'h3,
    S_HALT = 4'h4,
    S_IN_READY = 4'h5,
    S_IN_DESKEW = 4'h6,
    S_IN_LOW = 4'h7
  } fbp_state_e_t;

  // FIFO word: data plus the end marks carried beside it
  typedef struct packed {
    logic host_end_output;
    logic peripheral_end_input;
    logic [15:0] data;
  } fbp_word_t;

  typedef struct packed {
    logic [15:0] data;
    logic data_oe;
    logic peripheral_control_strobe;
    logic host_end_output_n;
  } fbp_front_t;

  typedef struct packed {
    fbp_state_e_t fsm;
    logic [2:0] tmr;
    logic dir;
    logic [1:0] flag_sy;
    logic flag_prev;
    logic [1:0] peripheral_end_input_sy;
    logic peripheral_end_input_prev;
    logic [1:0] pwr_sy;
    logic [15:0] din_sy1;
    logic [15:0] din_sy2;
    fbp_front_t front;
    fbp_word_t in_word;
    logic push;
    logic pop;
    logic halted;
    logic bursting;
    logic [5:0] words;
    logic bp_req;
    logic poll_ans;
  } fbp_regs_t;

endpackage : fbp_pkg

// *** core/fbp_pacer.sv ***
// burst pacing toward the backplane and FIFO-mode handshake toward the frontplane
`timescale 1ns/100ps
`default_nettype none

module fbp_pacer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic out_dir_i,
  input wire logic edge_select_i,
  input wire logic poll_i,
  input wire logic grant_i,
  input wire logic bp_word_i,
  input wire logic [6:0] fifo_count_i,
  output logic poll_answer_o,
  output logic burst_request_n_o,
  input wire logic out_valid_i,
  input wire fbp_pkg::fbp_word_t out_word_i,
  output logic out_pop_o,
  input wire logic in_ready_i,
  input wire logic in_last_i,
  output logic in_push_o,
  output fbp_pkg::fbp_word_t in_word_o,
  input wire logic peripheral_flag_input_i,
  input wire logic peripheral_end_input_i,
  input wire logic peer_power_i,
  input wire logic [15:0] front_data_i,
  output fbp_pkg::fbp_front_t front_o,
  output logic halted_o
);

  fbp_pkg::fbp_regs_t q;
  fbp_pkg::fbp_regs_t d;
  logic flag_eff;
  logic flag_rise;
  logic peripheral_end_input_fall;
  logic bp_ok;
  logic burst_end;
  logic [6:0] cnt_next;

  // only the second stage of each synchroniser feeds logic
  assign flag_eff = ~(q.flag_sy[1] ^ edge_select_i);
  assign flag_rise = flag_eff & ~q.flag_prev;
  assign peripheral_end_input_fall = q.peripheral_end_input_prev & ~q.peripheral_end_input_sy[1];

  always_comb begin
    d = q;
    d.push = 1'b0;
    d.pop = 1'b0;
    d.poll_ans = 1'b0;
    d.flag_sy = {q.flag_sy[0], peripheral_flag_input_i};
    d.peripheral_end_input_sy = {q.peripheral_end_input_sy[0], peripheral_end_input_i};
    d.pwr_sy = {q.pwr_sy[0], peer_power_i};
    d.din_sy1 = front_data_i;
    d.din_sy2 = q.din_sy1;
    d.flag_prev = flag_eff;
    d.peripheral_end_input_prev = q.peripheral_end_input_sy[1];

    // output needs room below the high mark, input needs a worthwhile backlog
    if (out_dir_i) begin
      bp_ok = (fifo_count_i <= fbp_pkg::OUT_HIGH_MARK) && (fifo_count_i < fbp_pkg::FIFO_DEPTH);
    end else begin
      bp_ok = fifo_count_i >= fbp_pkg::IN_MIN_WORDS;
    end
    // the count lags the word strobe, so judge the level this word leaves behind
    cnt_next = q.dir ? fifo_count_i + 7'h01 : fifo_count_i - 7'h01;
    if (q.dir) begin
      burst_end = (cnt_next > fbp_pkg::OUT_HIGH_MARK) || (cnt_next >= fbp_pkg::FIFO_DEPTH);
    end else begin
      burst_end = cnt_next == 7'h00;
    end
    if ((q.words + 6'h01) == fbp_pkg::BURST_MAX) begin
      burst_end = 1'b1;
    end

    d.poll_ans = poll_i & enable_i & bp_ok & (q.fsm != fbp_pkg::S_IDLE);
    if (!q.bursting) begin
      if (grant_i && enable_i && bp_ok && (q.fsm != fbp_pkg::S_IDLE)) begin
        d.bursting = 1'b1;
        d.bp_req = 1'b1;
        d.words = 6'h00;
      end
    end else if (!enable_i) begin
      d.bursting = 1'b0;
      d.bp_req = 1'b0;
    end else if (bp_word_i) begin
      d.words = q.words + 6'h01;
      if (burst_end) begin
        d.bursting = 1'b0;
        d.bp_req = 1'b0;
      end
    end

    case (q.fsm)
      fbp_pkg::S_IDLE: begin
        d.front.peripheral_control_strobe = 1'b0;
        d.front.data_oe = 1'b0;
        d.front.host_end_output_n = 1'b1;
        // standby until the far machine is seen powered
        if (enable_i && q.pwr_sy[1]) begin
          d.dir = out_dir_i;
          d.front.data_oe = out_dir_i;
          d.fsm = out_dir_i ? fbp_pkg::S_LOAD : fbp_pkg::S_IN_READY;
        end
      end
      fbp_pkg::S_LOAD: begin
        d.front.peripheral_control_strobe = 1'b0;
        if (peripheral_end_input_fall) begin
          d.fsm = fbp_pkg::S_HALT;
          d.halted = 1'b1;
        end else if (out_valid_i) begin
          // peek only: the word leaves the FIFO when the peripheral takes it
          d.front.data = out_word_i.data;
          d.front.host_end_output_n = ~out_word_i.host_end_output;
          d.tmr = fbp_pkg::SETUP_CYC - 3'h1;
          d.fsm = fbp_pkg::S_SETUP;
        end
      end
      fbp_pkg::S_SETUP: begin
        if (peripheral_end_input_fall) begin
          d.fsm = fbp_pkg::S_HALT;
          d.halted = 1'b1;
        end else if (q.tmr == 3'h0) begin
          d.front.peripheral_control_strobe = 1'b1;
          d.fsm = fbp_pkg::S_STROBE;
        end else begin
          d.tmr = q.tmr - 3'h1;
        end
      end
      fbp_pkg::S_STROBE: begin
        // the flag answer is the far side's job; we only wait for it
        if (flag_rise) begin
          d.front.peripheral_control_strobe = 1'b0;
          d.pop = 1'b1;
          d.fsm = fbp_pkg::S_LOAD;
        end
      end
      fbp_pkg::S_HALT: begin
        d.front.peripheral_control_strobe = 1'b0;
      end
      fbp_pkg::S_IN_READY: begin
        d.front.peripheral_control_strobe = in_ready_i;
        if (in_ready_i && !q.front.peripheral_control_strobe) begin
          d.front.host_end_output_n = ~in_last_i;
        end
        if (q.front.peripheral_control_strobe && flag_rise) begin
          d.tmr = fbp_pkg::DESKEW_CYC - 3'h1;
          d.fsm = fbp_pkg::S_IN_DESKEW;
        end else if (q.front.peripheral_control_strobe && !in_ready_i) begin
          // a lost slot still owes the peripheral a full-width low pulse
          d.tmr = fbp_pkg::STROBE_LOW_CYC - 3'h1;
          d.fsm = fbp_pkg::S_IN_LOW;
        end
      end
      fbp_pkg::S_IN_DESKEW: begin
        if (q.tmr == 3'h0) begin
          d.push = 1'b1;
          d.in_word = '{host_end_output: 1'b0, peripheral_end_input: ~q.peripheral_end_input_sy[1], data: q.din_sy2};
          d.front.peripheral_control_strobe = 1'b0;
          d.tmr = fbp_pkg::STROBE_LOW_CYC - 3'h1;
          d.fsm = fbp_pkg::S_IN_LOW;
        end else begin
          d.tmr = q.tmr - 3'h1;
        end
      end
      fbp_pkg::S_IN_LOW: begin
        d.front.host_end_output_n = 1'b1;
        if (q.tmr == 3'h0) begin
          d.fsm = fbp_pkg::S_IN_READY;
        end else begin
          d.tmr = q.tmr - 3'h1;
        end
      end
      default: begin
        d.fsm = fbp_pkg::S_IDLE;
      end
    endcase

    // losing enable or the peer drops the link back to standby at once
    if (q.fsm != fbp_pkg::S_IDLE && (!enable_i || !q.pwr_sy[1])) begin
      d.fsm = fbp_pkg::S_IDLE;
      d.halted = 1'b0;
      d.pop = 1'b0;
      d.push = 1'b0;
      d.front.peripheral_control_strobe = 1'b0;
      d.front.data_oe = 1'b0;
      d.front.host_end_output_n = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= '0;
      q.front.host_end_output_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign poll_answer_o = q.poll_ans;
  assign burst_request_n_o = ~q.bp_req;
  assign out_pop_o = q.pop;
  assign in_push_o = q.push;
  assign in_word_o = q.in_word;
  assign front_o = q.front;
  assign halted_o = q.halted;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_BURST_LEN: assert property (q.bursting && enable_i && bp_word_i && q.words == 6'h1f |=> burst_request_n_o)
    else $error("burst ran past thirty-two words");
  AST_BURST_SPACE: assert property (q.bursting && enable_i && bp_word_i
    && (q.dir ? fifo_count_i == 7'h3f : fifo_count_i == 7'h01)
    |=> burst_request_n_o && !q.bursting)
    else $error("burst continued with no words or spaces left");
  AST_HIGH_MARK: assert property (q.bursting && enable_i && q.dir && bp_word_i && fifo_count_i >= 7'h37
    |=> burst_request_n_o)
    else $error("output burst not ended above the high mark");
  AST_IN_MIN: assert property (!q.bursting && !out_dir_i && fifo_count_i < 7'h08 |=> !q.bursting)
    else $error("input burst started below eight words");
  AST_LOW_WIDTH: assert property ($fell(front_o.peripheral_control_strobe) && q.fsm != fbp_pkg::S_IDLE
    |-> !front_o.peripheral_control_strobe [*4])
    else $error("control strobe low pulse too short");
  AST_DATA_SETUP: assert property ($rose(front_o.peripheral_control_strobe) && q.dir
    |-> $past(front_o.data, 4) == front_o.data && $past(q.fsm == fbp_pkg::S_SETUP, 4))
    else $error("strobe rose without full data setup");
  AST_DESKEW: assert property (in_push_o |-> $past(q.fsm == fbp_pkg::S_IN_DESKEW, 1)
    && $past(q.fsm == fbp_pkg::S_IN_DESKEW, 4))
    else $error("input word taken before deskew ended");
  AST_DROP: assert property (q.fsm == fbp_pkg::S_STROBE && flag_rise && enable_i && q.pwr_sy[1]
    |=> !front_o.peripheral_control_strobe && out_pop_o ##1 !out_pop_o)
    else $error("strobe not dropped one clock after the flag");
  AST_ABORT: assert property (q.fsm == fbp_pkg::S_SETUP && peripheral_end_input_fall && enable_i && q.pwr_sy[1]
    |=> q.fsm == fbp_pkg::S_HALT ##1 !front_o.peripheral_control_strobe)
    else $error("end input did not abort the pending word");
  AST_FLAG_PATH: assert property (q.fsm == fbp_pkg::S_STROBE && $stable(edge_select_i)
    && $past(peripheral_flag_input_i, 2) != edge_select_i && enable_i && q.pwr_sy[1]
    |=> front_o.peripheral_control_strobe)
    else $error("flag seen without the synchronised exclusive-NOR path");
  AST_STANDBY: assert property (q.fsm == fbp_pkg::S_IDLE && !q.pwr_sy[1] |=> q.fsm == fbp_pkg::S_IDLE)
    else $error("link left standby with the peer unpowered");
  AST_ONE_TALKER: assert property (front_o.data_oe |-> q.dir && !in_push_o)
    else $error("data driven while listening");

  COV_OUT_WORD: cover property (q.fsm == fbp_pkg::S_STROBE ##[1:50] out_pop_o);
  COV_IN_WORD: cover property (in_push_o);
  COV_FULL_BURST: cover property (q.bursting && bp_word_i && q.words == 6'h1f);
  COV_ABORT: cover property ($rose(halted_o));
  COV_PEER_LOSS: cover property (q.fsm != fbp_pkg::S_IDLE && !q.pwr_sy[1]);

endmodule : fbp_pacer

`default_nettype wire

// *** verif/fbp_periph_model.sv ***
// behavioural frontplane peripheral answering the control strobe with its flag
`timescale 1ns/100ps
`default_nettype none

module fbp_periph_model (
  input wire logic clock_i,
  input wire logic strobe_i,
  input wire logic flip_i,
  input wire logic [3:0] hold_i,
  input wire logic [15:0] word_i,
  input wire logic abort_i,
  input wire logic power_off_i,
  output logic flag_o,
  output logic end_n_o,
  output logic power_o,
  output logic [15:0] data_o
);
  logic raw_q = 1'b0;
  logic [3:0] wait_q = 4'h0;

  // flag rises after the hold-off once the strobe is seen high, and falls when it is seen low
  always @(posedge clock_i) begin
    if (strobe_i !== 1'b1) begin
      raw_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q < hold_i) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      raw_q <= 1'b1;
    end
  end

  // flip lets the bench present the flag in either polarity
  assign flag_o = raw_q ^ flip_i;
  // released data lines show the inverse so a stale word cannot pass as valid
  assign data_o = raw_q ? word_i : ~word_i;
  // the end mark follows the bench's abort input directly, at any time, whatever word the device accepts
  assign end_n_o = ~abort_i;
  assign power_o = ~power_off_i;
endmodule : fbp_periph_model

`default_nettype wire

// *** verif/test_fifo_burst_and_handshake_pacing.sv ***
// self-checking bench for the burst pacer and frontplane handshake
`timescale 1ns/100ps
`default_nettype none

module test_fifo_burst_and_handshake_pacing;
  logic clock_i, rst_i = 1'b1, en = 1'b0, dir = 1'b0, es = 1'b1, poll = 1'b0, grant = 1'b0, bpw = 1'b0;
  logic ov = 1'b0, ir = 1'b0, il = 1'b0, flip = 1'b0, abrt = 1'b0, poff = 1'b0;
  logic [6:0] cnt = 7'h00;
  logic [3:0] hold = 4'h0;
  logic [15:0] pw = 16'h0000, pd;
  fbp_pkg::fbp_word_t ow = '0, iw;
  fbp_pkg::fbp_front_t fr;
  logic ans, req_n, pop, push, halt, flag, endn, pwr;
  int error_cnt = 0, samples_checked = 0, pops = 0, cycles = 0;

  fbp_pacer u_dut (
    .clock_i(clock_i), .rst_i(rst_i), .enable_i(en), .out_dir_i(dir), .edge_select_i(es),
    .poll_i(poll), .grant_i(grant), .bp_word_i(bpw), .fifo_count_i(cnt), .poll_answer_o(ans),
    .burst_request_n_o(req_n), .out_valid_i(ov), .out_word_i(ow), .out_pop_o(pop),
    .in_ready_i(ir), .in_last_i(il), .in_push_o(push), .in_word_o(iw),
    .peripheral_flag_input_i(flag), .peripheral_end_input_i(endn), .peer_power_i(pwr),
    .front_data_i(pd), .front_o(fr), .halted_o(halt)
  );

  fbp_periph_model u_periph (
    .clock_i(clock_i), .strobe_i(fr.peripheral_control_strobe), .flip_i(flip), .hold_i(hold),
    .word_i(pw), .abort_i(abrt), .power_off_i(poff), .flag_o(flag), .end_n_o(endn), .power_o(pwr),
    .data_o(pd)
  );

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  // the whole run needs well under 2000 cycles
  always @(negedge clock_i) begin
    cycles++;
    if (pop === 1'b1) pops++;
    if (cycles == 6000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {18'h00000, exp}, {18'h00000, got});
  endtask : chkb

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  // direction is taken only on leaving idle, so every mode change passes through idle
  task automatic mode(input logic d, input logic e);
    en = 1'b0;
    cyc(2);
    dir = d;
    es = e;
    flip = ~e;
    en = 1'b1;
    cyc(4);
  endtask : mode

  task automatic t_out(input logic e, input logic [3:0] h, input logic hd);
    int n;
    logic [15:0] d;
    d = {12'ha5c, h};
    hold = h;
    mode(1'b1, e);
    ow = {hd, 1'b0, d};
    ov = 1'b1;
    for (n = 0; n < 20 && fr.data !== d; n++) cyc(1);
    for (n = 0; n < 20 && fr.peripheral_control_strobe !== 1'b1; n++) cyc(1);
    chk("setup", 19'(fbp_pkg::SETUP_CYC), 19'(n));
    chk("front", {d, 1'b1, 1'b1, ~hd}, fr);
    for (n = 0; n < 40 && pop !== 1'b1; n++) cyc(1);
    chkb("strobe_at_pop", 1'b0, fr.peripheral_control_strobe);
    ow = {2'b00, ~d};
    for (n = 0; n < 20 && fr.peripheral_control_strobe !== 1'b1; n++) cyc(1);
    chkb("strobe_low", 1'b1, n >= fbp_pkg::STROBE_LOW_CYC);
    chk("front2", {~d, 1'b1, 1'b1, 1'b1}, fr);
    for (n = 0; n < 40 && pop !== 1'b1; n++) cyc(1);
    ov = 1'b0;
    chkb("pop2", 1'b1, pop);
  endtask : t_out

  task automatic t_abort();
    int p;
    mode(1'b1, 1'b1);
    p = pops;
    ov = 1'b1;
    cyc(1);
    abrt = 1'b1;
    cyc(12);
    chkb("halted", 1'b1, halt);
    chkb("strobe_halted", 1'b0, fr.peripheral_control_strobe);
    chk("pops", 19'(p), 19'(pops));
    ov = 1'b0;
    abrt = 1'b0;
    en = 1'b0;
    cyc(3);
    chkb("halt_clear", 1'b0, halt);
  endtask : t_abort

  task automatic t_in();
    int n;
    hold = 4'h2;
    mode(1'b0, 1'b1);
    chkb("oe_listening", 1'b0, fr.data_oe);
    // a slot offered for one cycle and withdrawn still gets a full low pulse
    ir = 1'b1;
    cyc(1);
    ir = 1'b0;
    cyc(1);
    ir = 1'b1;
    for (n = 0; n < 20 && fr.peripheral_control_strobe !== 1'b1; n++) cyc(1);
    chkb("in_strobe_low", 1'b1, n >= fbp_pkg::STROBE_LOW_CYC);
    for (int k = 0; k < 2; k++) begin
      pw = 16'h3c00 + 16'(k);
      abrt = k[0];
      il = k[0];
      for (n = 0; n < 40 && flag !== 1'b1; n++) cyc(1);
      chkb("host_end_n", ~k[0], fr.host_end_output_n);
      for (n = 0; n < 40 && push !== 1'b1; n++) cyc(1);
      // two synchroniser stages and the edge detector come before the deskew wait
      chk("deskew", 19'(fbp_pkg::DESKEW_CYC) + 19'h00003, 19'(n));
      chk("in_word", {2'b00, k[0], pw}, {1'b0, iw});
      chkb("strobe_at_push", 1'b0, fr.peripheral_control_strobe);
      cyc(1);
    end
    ir = 1'b0;
    il = 1'b0;
    abrt = 1'b0;
  endtask : t_in

  // len 0 means the poll must go unanswered and the grant ignored
  task automatic t_burst(input logic d, input logic [6:0] c0, input logic up, input int len);
    logic [6:0] c;
    c = c0;
    mode(d, 1'b1);
    cnt = c;
    poll = 1'b1;
    cyc(1);
    poll = 1'b0;
    chkb("answer", len != 0, ans);
    grant = 1'b1;
    cyc(1);
    grant = 1'b0;
    chkb("request_n", len == 0, req_n);
    for (int i = 1; i <= len; i++) begin
      bpw = 1'b1;
      cyc(1);
      bpw = 1'b0;
      chkb("request_n", i == len, req_n);
      c = up ? c + 7'h01 : c - 7'h01;
      cnt = c;
      cyc(1);
    end
  endtask : t_burst

  // losing the peer drops the link to standby, where it waits until power returns
  task automatic t_power();
    mode(1'b1, 1'b1);
    chkb("oe_linked", 1'b1, fr.data_oe);
    poff = 1'b1;
    cyc(8);
    chkb("oe_peer_off", 1'b0, fr.data_oe);
    chkb("host_end_n_off", 1'b1, fr.host_end_output_n);
    chkb("strobe_peer_off", 1'b0, fr.peripheral_control_strobe);
    poff = 1'b0;
    cyc(4);
    chkb("oe_peer_back", 1'b1, fr.data_oe);
  endtask : t_power

  initial begin
    cyc(8);
    rst_i = 1'b0;
    cyc(2);
    t_out(1'b1, 4'h0, 1'b1);
    t_out(1'b0, 4'h6, 1'b0);
    t_abort();
    t_in();
    t_burst(1'b1, 7'h32, 1'b1, 6);
    t_burst(1'b1, 7'h38, 1'b1, 0);
    t_burst(1'b0, 7'h07, 1'b0, 0);
    t_burst(1'b0, 7'h08, 1'b0, 8);
    t_burst(1'b0, 7'h3f, 1'b0, 32);
    t_power();
    wrap_up();
  end
endmodule : test_fifo_burst_and_handshake_pacing

`default_nettype wire
